// ==== rtl/rxll_buf.sv ====
/*
  rxll_buf.sv: two-entry valid/ready buffer for lane words.
  assumes: single clock, asynchronous active-high reset.
*/
`default_nettype none
`include "rxll_defines.svh"

module rxll_buf (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire rxll_pkg::rxll_beat_t in_beat,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output rxll_pkg::rxll_beat_t out_beat
);
  import rxll_pkg::*;

  rxll_beat_t mem_ff [`RXLL_BUF_DEPTH];
  rxll_beat_t nxt_mem [`RXLL_BUF_DEPTH];
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic rd_ff;
  logic nxt_rd;
  logic wr_ff;
  logic nxt_wr;
  logic push;
  logic pop;

  // handshakes against honest full and empty
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_beat = mem_ff[rd_ff];

  // next pointers, count and storage
  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    if (flush) begin
      nxt_cnt = 2'h0;
      nxt_rd = 1'b0;
      nxt_wr = 1'b0;
    end else begin
      if (push) begin
        nxt_mem[wr_ff] = in_beat;
        nxt_wr = ~wr_ff;
      end
      if (pop) begin
        nxt_rd = ~rd_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      mem_ff <= nxt_mem;
    end
  end
endmodule

`default_nettype wire

// ==== rtl/rxll_defines.svh ====
/*
  rxll_defines.svh: constants of the receive link-layer port block.
  assumes: included by its bare name from rtl files; definitions only.
*/
`ifndef RXLL_DEFINES_SVH
`define RXLL_DEFINES_SVH

// lane count and word geometry
`define RXLL_LANES 4
`define RXLL_WORD_W 32
`define RXLL_OCTET_W 8
`define RXLL_OCTETS 4
// reconfiguration port arrangement: 0 shared, 1 vector, 2 per channel
`define RXLL_RCFG_SHARED 0
`define RXLL_RCFG_VECTOR 1
`define RXLL_RCFG_PERCH 2
`define RXLL_RCFG_MODE 1
`define RXLL_RCFG_EN 1
// reconfiguration access latency in cycles, as it would be at 250 MHz
`define RXLL_RCFG_LAT_NS 8
`define RXLL_CLK_NS 4
`define RXLL_RCFG_LAT_CYC ((`RXLL_RCFG_LAT_NS + `RXLL_CLK_NS - 1) / `RXLL_CLK_NS)
// receiver settle count after hard reset release
`define RXLL_SETTLE_NS 64
`define RXLL_SETTLE_CYC (`RXLL_SETTLE_NS / `RXLL_CLK_NS)
// buffer depth
`define RXLL_BUF_DEPTH 2

`endif

// ==== rtl/rxll_pkg.sv ====
/*
  rxll_pkg.sv: types of the receive link-layer port block.
  assumes: rxll_defines.svh is on the include path.
*/
`default_nettype none
`include "rxll_defines.svh"

package rxll_pkg;
  // one lane-data word group across all lanes
  typedef logic [`RXLL_LANES*`RXLL_WORD_W-1:0] rxll_data_t;
  // per-lane flags
  typedef logic [`RXLL_LANES-1:0] rxll_lanes_t;
  // beat carried through the stream buffer
  typedef struct packed {
    rxll_data_t data;
  } rxll_beat_t;
  // reconfiguration strobes
  typedef struct packed {
    rxll_lanes_t wr;
    rxll_lanes_t rd;
  } rxll_rcfg_t;
  // receive bring-up state
  typedef enum logic [1:0] {
    RXLL_ST_RESET = 2'b00,
    RXLL_ST_SETTLE = 2'b01,
    RXLL_ST_READY = 2'b10
  } rxll_state_t;
endpackage

`default_nettype wire

// ==== rtl/rxll_top.sv ====
/*
  rxll_top.sv: receive link-layer port logic: reconfiguration strobe
  handling, per-lane receiver ready, hard reset of the receive
  interface, and the lane-word stream toward the transport layer.
  assumes: transceiver octets arrive synchronous to clk, one octet per
  lane per cycle with a valid; sink drives ready and frame fault.
*/
// Summary of operation
// - reconfig write/read strobes and wait request: shared, per-lane vector, or per channel
// - reconfiguration ports always exist; with dynamic reconfiguration disabled, wait request stays low
// - per-lane receive-ready output, one bit per lane
// - single-bit receive hard reset is active high, resets receive interface
// - hard reset leaves attachment alone; attachment reset goes via reconfiguration
// - 32 bits per lane, big endian, earliest octet in top byte
// - one-bit valid; words sent while valid high, no backpressure from sink
`default_nettype none
`include "rxll_defines.svh"

module rxll_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // receive hard reset and attachment status
  input wire logic rx_hard_rst,
  input wire rxll_pkg::rxll_lanes_t pma_ready_in,
  output rxll_pkg::rxll_lanes_t pma_ready,
  output rxll_pkg::rxll_lanes_t rx_ready,
  // reconfiguration strobes
  input wire rxll_pkg::rxll_rcfg_t rcfg_strobe,
  output rxll_pkg::rxll_lanes_t rcfg_waitrequest,
  // octets from the transceiver
  input wire rxll_pkg::rxll_lanes_t lane_oct_valid,
  input wire logic [`RXLL_LANES*`RXLL_OCTET_W-1:0] lane_oct,
  // stream to the transport layer
  output rxll_pkg::rxll_data_t lane_word_out,
  output logic lane_word_valid,
  input wire logic sink_accept_ready,
  input wire logic sink_frame_fault,
  // status
  output logic frame_fault_seen,
  output logic word_dropped
);
  import rxll_pkg::*;

  localparam logic [7:0] LAT_CYC = 8'(`RXLL_RCFG_LAT_CYC);
  localparam logic [7:0] SETTLE_CYC = 8'(`RXLL_SETTLE_CYC);

  // merge strobes of one lane into an access request
  function automatic logic lane_req(input rxll_rcfg_t s, input int idx);
    lane_req = s.wr[idx] | s.rd[idx];
  endfunction

  // ---- receive bring-up
  rxll_state_t st_ff;
  rxll_state_t nxt_st;
  logic [7:0] settle_ff;
  logic [7:0] nxt_settle;
  rxll_lanes_t pma_ff;
  rxll_lanes_t rdy_ff;
  rxll_lanes_t nxt_rdy;

  // hard reset clears the receive path only; attachment status passes on
  always_comb begin
    nxt_st = st_ff;
    nxt_settle = settle_ff;
    unique case (st_ff)
      RXLL_ST_RESET: begin
        nxt_settle = 8'h00;
        if (!rx_hard_rst) begin
          nxt_st = RXLL_ST_SETTLE;
        end
      end
      RXLL_ST_SETTLE: begin
        nxt_settle = settle_ff + 8'h01;
        if (settle_ff == SETTLE_CYC - 8'h01) begin
          nxt_st = RXLL_ST_READY;
        end
      end
      RXLL_ST_READY: begin
        nxt_settle = 8'h00;
      end
      default: begin
        nxt_st = RXLL_ST_RESET;
      end
    endcase
    if (rx_hard_rst) begin
      nxt_st = RXLL_ST_RESET;
    end
    nxt_rdy = (st_ff == RXLL_ST_READY && !rx_hard_rst) ? pma_ready_in : '0;
  end

  // bring-up registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= RXLL_ST_RESET;
      settle_ff <= 8'h00;
      pma_ff <= '0;
      rdy_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      settle_ff <= nxt_settle;
      pma_ff <= pma_ready_in;
      rdy_ff <= nxt_rdy;
    end
  end

  assign pma_ready = pma_ff;
  assign rx_ready = rdy_ff;

  // ---- reconfiguration wait request per lane
  logic [7:0] busy_ff [`RXLL_LANES];
  logic [7:0] nxt_busy [`RXLL_LANES];
  rxll_lanes_t wait_ff;
  rxll_lanes_t nxt_wait;

  // each access holds wait request for the access latency
  always_comb begin
    for (int i = 0; i < `RXLL_LANES; i++) begin
      int src;
      src = (`RXLL_RCFG_MODE == `RXLL_RCFG_SHARED) ? 0 : i;
      nxt_busy[i] = busy_ff[i];
      if (`RXLL_RCFG_EN == 0) begin
        nxt_busy[i] = 8'h00;
      end else if (busy_ff[i] != 8'h00) begin
        nxt_busy[i] = busy_ff[i] - 8'h01;
      end else if (lane_req(rcfg_strobe, src)) begin
        nxt_busy[i] = LAT_CYC;
      end
      nxt_wait[i] = (nxt_busy[i] != 8'h00);
    end
  end

  // wait request registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `RXLL_LANES; i++) begin
        busy_ff[i] <= 8'h00;
      end
      wait_ff <= '0;
    end else begin
      busy_ff <= nxt_busy;
      wait_ff <= nxt_wait;
    end
  end

  assign rcfg_waitrequest = wait_ff;

  // ---- octet packing, big endian per lane
  logic [1:0] oct_cnt_ff [`RXLL_LANES];
  logic [1:0] nxt_oct_cnt [`RXLL_LANES];
  rxll_data_t acc_ff;
  rxll_data_t nxt_acc;
  rxll_lanes_t done_ff;
  rxll_lanes_t nxt_done;
  logic pack_valid;
  logic buf_in_ready;
  rxll_beat_t pack_beat;

  assign pack_valid = &done_ff;
  assign pack_beat.data = acc_ff;

  // first octet lands in the top byte of each lane word
  always_comb begin
    nxt_acc = acc_ff;
    nxt_done = done_ff;
    for (int i = 0; i < `RXLL_LANES; i++) begin
      nxt_oct_cnt[i] = oct_cnt_ff[i];
    end
    if (pack_valid && buf_in_ready) begin
      nxt_done = '0;
    end
    for (int i = 0; i < `RXLL_LANES; i++) begin
      if (st_ff != RXLL_ST_READY) begin
        nxt_oct_cnt[i] = 2'h0;
        nxt_done[i] = 1'b0;
      end else if (lane_oct_valid[i] && !(done_ff[i] && !(pack_valid && buf_in_ready))) begin
        nxt_acc[i*`RXLL_WORD_W + (3 - oct_cnt_ff[i])*`RXLL_OCTET_W +: `RXLL_OCTET_W] =
          lane_oct[i*`RXLL_OCTET_W +: `RXLL_OCTET_W];
        nxt_oct_cnt[i] = oct_cnt_ff[i] + 2'h1;
        if (oct_cnt_ff[i] == 2'h3) begin
          nxt_done[i] = 1'b1;
        end
      end
    end
  end

  // packing registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `RXLL_LANES; i++) begin
        oct_cnt_ff[i] <= 2'h0;
      end
      acc_ff <= '0;
      done_ff <= '0;
    end else begin
      oct_cnt_ff <= nxt_oct_cnt;
      acc_ff <= nxt_acc;
      done_ff <= nxt_done;
    end
  end

  // ---- stream buffer toward the sink
  logic buf_out_valid;
  rxll_beat_t buf_out_beat;
  logic take;

  // the stream cannot be held off; words leave as soon as buffered
  assign take = buf_out_valid;

  rxll_buf u_buf (
    .clk(clk),
    .rst(rst),
    .flush(st_ff != RXLL_ST_READY),
    .in_valid(pack_valid),
    .in_ready(buf_in_ready),
    .in_beat(pack_beat),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_beat(buf_out_beat)
  );

  // output stage and status
  rxll_data_t nxt_out;
  logic nxt_valid;
  logic nxt_fault;
  logic nxt_drop;
  rxll_data_t out_ff;
  logic valid_ff;
  logic fault_ff;
  logic drop_ff;

  always_comb begin
    nxt_out = take ? buf_out_beat.data : out_ff;
    nxt_valid = take;
    nxt_fault = fault_ff | sink_frame_fault;
    nxt_drop = drop_ff | (valid_ff && !sink_accept_ready);
    if (rx_hard_rst) begin
      nxt_fault = 1'b0;
      nxt_drop = 1'b0;
      nxt_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ff <= '0;
      valid_ff <= 1'b0;
      fault_ff <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      valid_ff <= nxt_valid;
      fault_ff <= nxt_fault;
      drop_ff <= nxt_drop;
    end
  end

  assign lane_word_out = out_ff;
  assign lane_word_valid = valid_ff;
  assign frame_fault_seen = fault_ff;
  assign word_dropped = drop_ff;
endmodule

`default_nettype wire

// ==== verif/rxll_sink_model.sv ====
/* rxll_sink_model.sv: transport-layer sink keeping the last two words.
   assumes: words arrive on clk and are never stalled. */
`default_nettype none
module rxll_sink_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stream from the link layer
  input wire rxll_pkg::rxll_data_t lane_word_out,
  input wire logic lane_word_valid,
  output logic sink_accept_ready,
  output logic sink_frame_fault,
  // bench control and view
  input wire logic stall,
  input wire logic fault,
  output rxll_pkg::rxll_data_t last,
  output rxll_pkg::rxll_data_t prev,
  output logic [7:0] n_words
);
  timeunit 1ns;
  timeprecision 1ps;
  import rxll_pkg::*;
  // ready unless told to stall, fault on request
  assign sink_accept_ready = !stall;
  assign sink_frame_fault = fault;
  // take every word shown, ready or not
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n_words <= 8'h00;
    end else if (lane_word_valid) begin
      prev <= last;
      last <= lane_word_out;
      n_words <= n_words + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verif/rxll_top_sva.sv ====
/* rxll_top_sva.sv: port checks of rxll_top.
   assumes: bound to rxll_top; one clock; rst async high. */
`default_nettype none
module rxll_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // receive status
  input wire logic rx_hard_rst,
  input wire rxll_pkg::rxll_lanes_t pma_ready_in,
  input wire rxll_pkg::rxll_lanes_t pma_ready,
  input wire rxll_pkg::rxll_lanes_t rx_ready,
  // reconfiguration
  input wire rxll_pkg::rxll_rcfg_t rcfg_strobe,
  input wire rxll_pkg::rxll_lanes_t rcfg_waitrequest,
  // stream
  input wire logic lane_word_valid,
  input wire logic sink_accept_ready,
  input wire logic sink_frame_fault,
  input wire logic frame_fault_seen,
  input wire logic word_dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  import rxll_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // stream flags
  property p_pulse;
    lane_word_valid |=> !lane_word_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid held");
  property p_drop;
    lane_word_valid && !sink_accept_ready && !rx_hard_rst |=> word_dropped;
  endproperty
  a_drop: assert property (p_drop) else $error("drop not flagged");
  property p_fault;
    sink_frame_fault && !rx_hard_rst |=> frame_fault_seen;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not seen");
  // readiness and hard reset
  property p_rdy_sub;
    (rx_ready & ~$past(pma_ready_in)) == '0;
  endproperty
  a_rdy_sub: assert property (p_rdy_sub) else $error("ready without lane");
  property p_hard_off;
    rx_hard_rst [*2] |-> rx_ready == '0 && !lane_word_valid;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("active in reset");
  property p_settle;
    $fell(rx_hard_rst) |-> (rx_ready == '0) [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("ready too soon");
  property p_pma;
    rx_hard_rst [*2] |-> pma_ready == $past(pma_ready_in);
  endproperty
  a_pma: assert property (p_pma) else $error("attachment touched");
  // reconfiguration wait on lane 0
  property p_wait_go;
    (rcfg_strobe.wr[0] || rcfg_strobe.rd[0]) && !rcfg_waitrequest[0] && !rx_hard_rst |=> rcfg_waitrequest[0];
  endproperty
  a_wait_go: assert property (p_wait_go) else $error("no wait");
  property p_wait_len;
    $rose(rcfg_waitrequest[0]) |-> ##1 rcfg_waitrequest[0] ##1 !rcfg_waitrequest[0];
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait length");
  property p_wait_why;
    $rose(rcfg_waitrequest[0]) |-> $past(rcfg_strobe.wr[0]) || $past(rcfg_strobe.rd[0]);
  endproperty
  a_wait_why: assert property (p_wait_why) else $error("wait uncaused");
  // main scenarios
  c_word: cover property (lane_word_valid);
  c_wait: cover property ($rose(rcfg_waitrequest[0]));
  c_drop: cover property (word_dropped);
endmodule
bind rxll_top rxll_top_sva i_rxll_top_sva (.clk(clk), .rst(rst), .rx_hard_rst(rx_hard_rst),
  .pma_ready_in(pma_ready_in), .pma_ready(pma_ready), .rx_ready(rx_ready), .rcfg_strobe(rcfg_strobe),
  .rcfg_waitrequest(rcfg_waitrequest), .lane_word_valid(lane_word_valid),
  .sink_accept_ready(sink_accept_ready), .sink_frame_fault(sink_frame_fault),
  .frame_fault_seen(frame_fault_seen), .word_dropped(word_dropped));
`default_nettype wire

// ==== verif/test_rxll_top.sv ====
/* test_rxll_top.sv: scenario bench of rxll_top with a sink model.
   assumes: rxll_pkg and the design are compiled first. */
`default_nettype none
module test_rxll_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rxll_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hrst = 1'b1;
  logic stall = 1'b0;
  logic fault = 1'b0;
  logic wv, rdy, flt, fseen, drop;
  logic [7:0] nw;
  logic [31:0] oct = '0;
  rxll_lanes_t pin = 4'hf;
  rxll_lanes_t ov = '0;
  rxll_lanes_t prdy, rrdy, wreq;
  rxll_rcfg_t strb = '0;
  rxll_data_t word, last, prev;
  int n_fail = 0;
  int n_checks = 0;
  // clock
  always #2 clk = ~clk;
  // design and sink
  rxll_top i_rxll_top (.clk(clk), .rst(rst), .rx_hard_rst(hrst), .pma_ready_in(pin), .pma_ready(prdy),
    .rx_ready(rrdy), .rcfg_strobe(strb), .rcfg_waitrequest(wreq), .lane_oct_valid(ov), .lane_oct(oct),
    .lane_word_out(word), .lane_word_valid(wv), .sink_accept_ready(rdy), .sink_frame_fault(flt),
    .frame_fault_seen(fseen), .word_dropped(drop));
  rxll_sink_model i_rxll_sink_model (.clk(clk), .rst(rst), .lane_word_out(word), .lane_word_valid(wv),
    .sink_accept_ready(rdy), .sink_frame_fault(flt), .stall(stall), .fault(fault), .last(last),
    .prev(prev), .n_words(nw));
  // compare and report
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // octet k of lane i is base + 16i + k
  function automatic rxll_data_t exp_word(input logic [7:0] b);
    exp_word = '0;
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 4; k++)
        exp_word[32*i+24-8*k +: 8] = b + 8'(16*i + k);
  endfunction
  task automatic send(input logic [7:0] b);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      ov = 4'hf;
      for (int i = 0; i < 4; i++)
        oct[8*i +: 8] = b + 8'(16*i + k);
    end
  endtask
  task automatic wait_words(input int n);
    for (int i = 0; i < 40 && nw < 8'(n); i++)
      @(negedge clk);
    chk("words", 128'(nw), 128'(n));
    if (nw < 8'(n))
      close_out();
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 40 && rrdy !== 4'hf; i++)
      @(negedge clk);
    chk("rx ready", 128'(rrdy), 128'hf);
    if (rrdy !== 4'hf)
      close_out();
  endtask
  // hard reset held with attachment ready, then settle
  task automatic t_bring_up();
    repeat (3) @(negedge clk);
    chk("rx ready", 128'(rrdy), 128'h0);
    chk("pma ready", 128'(prdy), 128'hf);
    hrst = 1'b0;
    repeat (8) @(negedge clk);
    chk("rx ready", 128'(rrdy), 128'h0);
    wait_ready();
    pin = 4'h5;
    repeat (2) @(negedge clk);
    chk("rx ready", 128'(rrdy), 128'h5);
    pin = 4'hf;
    repeat (2) @(negedge clk);
  endtask
  // two words back to back
  task automatic t_words();
    send(8'h00);
    send(8'h80);
    @(negedge clk);
    ov = '0;
    wait_words(2);
    chk("word 1", prev, exp_word(8'h00));
    chk("word 2", last, exp_word(8'h80));
  endtask
  // sink not ready: word still sent, drop flagged
  task automatic t_stall();
    stall = 1'b1;
    send(8'h40);
    @(negedge clk);
    ov = '0;
    wait_words(3);
    chk("stalled word", last, exp_word(8'h40));
    chk("dropped", 128'(drop), 128'h1);
    stall = 1'b0;
  endtask
  // each lane, write then read, strobe held into busy
  task automatic t_rcfg();
    logic [3:0] m;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 2; j++) begin
        m = 4'(1 << i);
        @(negedge clk);
        strb = rxll_rcfg_t'((j == 1) ? {4'h0, m} : {m, 4'h0});
        @(negedge clk);
        chk("wait", 128'(wreq), 128'(m));
        @(negedge clk);
        strb = '0;
        chk("wait", 128'(wreq), 128'(m));
        @(negedge clk);
        chk("wait", 128'(wreq), 128'h0);
      end
  endtask
  // fault, then hard reset clears status and refuses octets
  task automatic t_fault();
    @(negedge clk);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    @(negedge clk);
    chk("fault seen", 128'(fseen), 128'h1);
    hrst = 1'b1;
    send(8'h11);
    @(negedge clk);
    ov = '0;
    chk("fault seen", 128'(fseen), 128'h0);
    chk("dropped", 128'(drop), 128'h0);
    chk("pma ready", 128'(prdy), 128'hf);
    hrst = 1'b0;
    wait_ready();
    repeat (8) @(negedge clk);
    chk("words", 128'(nw), 128'h3);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_bring_up();
    t_words();
    t_stall();
    t_rcfg();
    t_fault();
    close_out();
  end
endmodule
`default_nettype wire
